// file: rdc_pkg.sv
`default_nettype none
package rdc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DAC_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_DAC_LEVEL    = 8'h04;
  localparam logic [7:0] ADDR_CMP_CTRL_A0  = 8'h08;
  localparam logic [7:0] ADDR_CMP_CTRL_A1  = 8'h0C;
  localparam logic [7:0] ADDR_CMP_SUMMARY  = 8'h10;
  localparam logic [7:0] ADDR_PIN_DIR      = 8'h14;
  localparam logic [7:0] ADDR_PIN_LATCH    = 8'h18;
  localparam logic [7:0] ADDR_PIN_READ     = 8'h1C;
  localparam logic [7:0] ADDR_DAC_AUX      = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DAC_EN_BIT      = 7;
  localparam int DAC_OE1_BIT     = 5;
  localparam int DAC_OE2_BIT     = 4;
  localparam int DAC_PSS_BIT     = 2;
  localparam int DAC_LPS_BIT     = 0;
  localparam int CMP_EN_BIT      = 7;
  localparam int CMP_RES_BIT     = 6;
  localparam int CMP_OE_BIT      = 5;
  localparam int CMP_INV_BIT     = 4;
  localparam int CMP_SP_BIT      = 2;

  // ----------------------------------------------------------------
  // sizes, reset values, timing
  // ----------------------------------------------------------------
  localparam int NUM_CMP         = 2;
  localparam int NUM_PIN         = 4;
  localparam int CODE_W          = 5;
  localparam logic [4:0] CODE_MAX = 5'h1F;
  localparam logic [4:0] CODE_MIN = 5'h00;
  localparam logic [1:0] CMP_SP_RESET = 2'h3;
  localparam int INSTR_DIV       = 4;
  localparam logic [1:0] DIV_LAST = 2'(INSTR_DIV - 1);

  // registered answer state of the bus slave
  typedef enum logic {APB_IDLE, APB_ACCESS} rdc_apb_t;

endpackage
`default_nettype wire

// file: ref_dac_and_comparator_ctrl.sv
// Summary of operation
// - dac_enable bit 7 switches the DAC on
// - five-bit level code, upper bits read zero
// - enabled output follows code over 32 steps
// - disabled DAC ties to rail at extreme codes
// - bit 2 picks external reference or supply
// - bits 5 and 4 connect reference pins
// - connected pin loses digital driver and input
// - port read of reference pin returns zero
// - wake from sleep keeps DAC control intact
// - reset clears all DAC control bits
// - unimplemented DAC control bits read zero
// - comparator works only while enabled
// - result readable locally and in summary
// - pin driven needs enable, output, direction clear
// - output enable overrides latch regardless of enable
// - software result latched each instruction cycle
// - raw decision high when plus exceeds minus
// - invert bit complements the result
// - speed select resets to normal speed
// - comparator bits at 7,6,5,4,2
`timescale 1ns/1ps
`default_nettype none

module ref_dac_and_comparator_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [1:0]  cmpDecisionAsync,
  input  wire logic [3:0]  pinIn,
  output var  logic [3:0]  pinDrvOe,
  output var  logic [3:0]  pinDrvOut,
  output var  logic [3:0]  pinInEn,
  output var  logic        dacLadderOn,
  output var  logic [4:0]  dacTap,
  output var  logic        dacTieHigh,
  output var  logic        dacTieLow,
  output var  logic        dacSrcExt,
  output var  logic [1:0]  refConnect,
  output var  logic [1:0]  cmpPowerOn,
  output var  logic [1:0]  cmpFastMode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rdc_pkg::rdc_apb_t apb;
    logic [31:0] rdata;
    logic        err;
    logic        dac_enable;
    logic        dac_pin1_out_en;
    logic        dac_pin2_out_en;
    logic        dac_pos_source_sel;
    logic        dac_low_pos_sel;
    logic [4:0]  dacCode;
    logic [1:0]  cmpEn;
    logic [1:0]  cmpOe;
    logic [1:0]  cmpInv;
    logic [1:0]  cmpSp;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  cmpResult;
    logic [3:0]  pinDir;
    logic [3:0]  pinLatch;
    logic [1:0]  divCnt;
    logic [3:0]  drvOe;
    logic [3:0]  drvOut;
    logic [3:0]  inEn;
    logic        ladderOn;
    logic [4:0]  tap;
    logic        tieHigh;
    logic        tieLow;
    logic        srcExt;
    logic [1:0]  refConn;
    logic [1:0]  powerOn;
    logic [1:0]  fastMode;
  } rdc_state_t;

  rdc_state_t state_r;
  rdc_state_t state_nxt;

  // ----------------------------------------------------------------
  // register decode and read mux
  // ----------------------------------------------------------------
  // address to register slot, 4'hF when unmapped
  function automatic logic [3:0] regSlot(input logic [31:0] addr);
    logic [3:0] slot;
    slot = 4'hF;
    if (addr[31:8] == 24'h000000)
    begin
      unique case (addr[7:0])
        rdc_pkg::ADDR_DAC_CONTROL: slot = 4'h0;
        rdc_pkg::ADDR_DAC_LEVEL:   slot = 4'h1;
        rdc_pkg::ADDR_CMP_CTRL_A0: slot = 4'h2;
        rdc_pkg::ADDR_CMP_CTRL_A1: slot = 4'h3;
        rdc_pkg::ADDR_CMP_SUMMARY: slot = 4'h4;
        rdc_pkg::ADDR_PIN_DIR:     slot = 4'h5;
        rdc_pkg::ADDR_PIN_LATCH:   slot = 4'h6;
        rdc_pkg::ADDR_PIN_READ:    slot = 4'h7;
        rdc_pkg::ADDR_DAC_AUX:     slot = 4'h8;
        default:                   slot = 4'hF;
      endcase
    end
    return slot;
  endfunction

  // comparator control byte image
  function automatic logic [7:0] cmpImage(input rdc_state_t s, input int i);
    logic [7:0] v;
    v = 8'h00;
    v[rdc_pkg::CMP_EN_BIT]  = s.cmpEn[i];
    v[rdc_pkg::CMP_RES_BIT] = s.cmpResult[i];
    v[rdc_pkg::CMP_OE_BIT]  = s.cmpOe[i];
    v[rdc_pkg::CMP_INV_BIT] = s.cmpInv[i];
    v[rdc_pkg::CMP_SP_BIT]  = s.cmpSp[i];
    return v;
  endfunction

  logic [3:0] slot;
  logic [7:0] readByte;
  logic       setupPhase;
  logic       writeNow;

  assign slot       = regSlot(paddr);
  assign setupPhase = psel && !penable;
  assign writeNow   = (state_r.apb == rdc_pkg::APB_ACCESS) && psel && penable && pwrite;

  // read data selection
  always_comb
  begin
    readByte = 8'h00;
    unique case (slot)
      4'h0:
      begin
        // unimplemented positions stay zero
        readByte[rdc_pkg::DAC_EN_BIT]  = state_r.dac_enable;
        readByte[rdc_pkg::DAC_OE1_BIT] = state_r.dac_pin1_out_en;
        readByte[rdc_pkg::DAC_OE2_BIT] = state_r.dac_pin2_out_en;
        readByte[rdc_pkg::DAC_PSS_BIT] = state_r.dac_pos_source_sel;
      end
      4'h1: readByte = {3'h0, state_r.dacCode};
      4'h2: readByte = cmpImage(state_r, 0);
      4'h3: readByte = cmpImage(state_r, 1);
      4'h4: readByte = {6'h00, state_r.cmpResult};
      4'h5: readByte = {4'h0, state_r.pinDir};
      4'h6: readByte = {4'h0, state_r.pinLatch};
      // reference pins read zero while connected
      4'h7: readByte = {4'h0, pinIn[3:2], pinIn[1] & ~state_r.dac_pin2_out_en,
                        pinIn[0] & ~state_r.dac_pin1_out_en};
      4'h8: readByte = {7'h00, state_r.dac_low_pos_sel};
      default: readByte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;

    // two-phase slave: answer prepared in setup, shown in access
    if (state_r.apb == rdc_pkg::APB_IDLE)
    begin
      if (setupPhase)
      begin
        state_nxt.apb   = rdc_pkg::APB_ACCESS;
        state_nxt.err   = (slot == 4'hF);
        state_nxt.rdata = (pwrite || slot == 4'hF) ? 32'h0000_0000 : {24'h000000, readByte};
      end
    end
    else
    begin
      state_nxt.apb   = rdc_pkg::APB_IDLE;
      state_nxt.err   = 1'b0;
      state_nxt.rdata = 32'h0000_0000;
    end

    // register writes; only the device reset clears them
    if (writeNow)
    begin
      unique case (slot)
        4'h0:
        begin
          state_nxt.dac_enable  = pwdata[rdc_pkg::DAC_EN_BIT];
          state_nxt.dac_pin1_out_en = pwdata[rdc_pkg::DAC_OE1_BIT];
          state_nxt.dac_pin2_out_en = pwdata[rdc_pkg::DAC_OE2_BIT];
          state_nxt.dac_pos_source_sel = pwdata[rdc_pkg::DAC_PSS_BIT];
        end
        4'h1: state_nxt.dacCode = pwdata[rdc_pkg::CODE_W-1:0];
        4'h2, 4'h3:
        begin
          state_nxt.cmpEn[slot[0]]  = pwdata[rdc_pkg::CMP_EN_BIT];
          state_nxt.cmpOe[slot[0]]  = pwdata[rdc_pkg::CMP_OE_BIT];
          state_nxt.cmpInv[slot[0]] = pwdata[rdc_pkg::CMP_INV_BIT];
          state_nxt.cmpSp[slot[0]]  = pwdata[rdc_pkg::CMP_SP_BIT];
        end
        4'h5: state_nxt.pinDir   = pwdata[3:0];
        4'h6: state_nxt.pinLatch = pwdata[3:0];
        4'h8: state_nxt.dac_low_pos_sel   = pwdata[rdc_pkg::DAC_LPS_BIT];
        default: state_nxt.dac_low_pos_sel = state_r.dac_low_pos_sel;
      endcase
    end

    // instruction cycle divider
    state_nxt.divCnt = (state_r.divCnt == rdc_pkg::DIV_LAST) ? 2'h0 : state_r.divCnt + 2'h1;

    // comparator decision synchronizer
    state_nxt.sync1 = cmpDecisionAsync;
    state_nxt.sync2 = state_r.sync1;

    for (int i = 0; i < rdc_pkg::NUM_CMP; i++)
    begin
      // latched once per instruction cycle inverted gated
      if (state_r.divCnt == rdc_pkg::DIV_LAST)
        state_nxt.cmpResult[i] = state_r.cmpEn[i] & (state_r.sync2[i] ^ state_r.cmpInv[i]);
      state_nxt.powerOn[i]  = state_r.cmpEn[i];
      state_nxt.fastMode[i] = state_r.cmpSp[i];
      // pin data: override follows output enable only
      state_nxt.drvOut[2+i] = state_r.cmpOe[i] ? (state_r.sync2[i] ^ state_r.cmpInv[i])
                                               : state_r.pinLatch[2+i];
      // driving the result needs enable and cleared direction
      state_nxt.drvOe[2+i]  = ~state_r.pinDir[2+i] & ~(state_r.cmpOe[i] & ~state_r.cmpEn[i]);
      state_nxt.inEn[2+i]   = 1'b1;
    end

    // reference pins lose digital driver and detector
    state_nxt.refConn   = {state_r.dac_pin2_out_en, state_r.dac_pin1_out_en};
    state_nxt.drvOe[0]  = ~state_r.pinDir[0] & ~state_r.dac_pin1_out_en;
    state_nxt.drvOe[1]  = ~state_r.pinDir[1] & ~state_r.dac_pin2_out_en;
    state_nxt.drvOut[1:0] = state_r.pinLatch[1:0];
    state_nxt.inEn[0]   = ~state_r.dac_pin1_out_en;
    state_nxt.inEn[1]   = ~state_r.dac_pin2_out_en;

    // ladder control
    state_nxt.ladderOn = state_r.dac_enable;
    state_nxt.tap      = state_r.dacCode;
    state_nxt.srcExt   = state_r.dac_pos_source_sel;
    // rail ties of the idle ladder
    state_nxt.tieHigh  = ~state_r.dac_enable & state_r.dac_low_pos_sel & (state_r.dacCode == rdc_pkg::CODE_MAX);
    state_nxt.tieLow   = ~state_r.dac_enable & ~state_r.dac_low_pos_sel & (state_r.dacCode == rdc_pkg::CODE_MIN);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset clears all DAC bits except tieLow, which it sets, speed select comes up normal
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r       <= '0;
      state_r.cmpSp <= rdc_pkg::CMP_SP_RESET;
      state_r.inEn  <= 4'hF;
      state_r.drvOe <= 4'hF;
      state_r.tieLow <= 1'b1;
      state_r.fastMode <= rdc_pkg::CMP_SP_RESET; // mirror agrees with speed bits at once
    end
    else
      state_r <= state_nxt;
  end

  // output drive straight from the state register
  assign prdata      = state_r.rdata;
  assign pready      = (state_r.apb == rdc_pkg::APB_ACCESS);
  assign pslverr     = state_r.err;
  assign pinDrvOe    = state_r.drvOe;
  assign pinDrvOut   = state_r.drvOut;
  assign pinInEn     = state_r.inEn;
  assign dacLadderOn = state_r.ladderOn;
  assign dacTap      = state_r.tap;
  assign dacTieHigh  = state_r.tieHigh;
  assign dacTieLow   = state_r.tieLow;
  assign dacSrcExt   = state_r.srcExt;
  assign refConnect  = state_r.refConn;
  assign cmpPowerOn  = state_r.powerOn;
  assign cmpFastMode = state_r.fastMode;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  dac_enable_a: assert property ($rose(state_r.dac_enable) |=> dacLadderOn)
    else $error("ladder did not follow enable");
  level_zero_a: assert property (pready && !pwrite && slot == 4'h1 |-> prdata[31:5] == 27'h0)
    else $error("level register upper bits not zero");
  dac_ctrl_zero_a: assert property (pready && !pwrite && slot == 4'h0 |-> prdata[6] == 1'b0
                                    && prdata[3] == 1'b0 && prdata[1:0] == 2'h0)
    else $error("unimplemented control bits not zero");
  tie_high_a: assert property (dacTieHigh |-> !dacLadderOn && dacTap == 5'h1F)
    else $error("tie high outside idle full code");
  ref_pin_off_a: assert property (refConnect[0] |-> !pinDrvOe[0] && !pinInEn[0])
    else $error("reference pin still digital");
  pin_read_zero_a: assert property (pready && !pwrite && slot == 4'h7 && state_r.dac_pin1_out_en
                                    |-> prdata[0] == 1'b0)
    else $error("connected reference pin read nonzero");
  cmp_off_result_a: assert property (!state_r.cmpEn[0] ##1 !state_r.cmpEn[0] [*4]
                                     |-> state_r.cmpResult[0] == 1'b0)
    else $error("disabled comparator shows result");
  latch_period_a: assert property ($changed(state_r.cmpResult) |-> $past(state_r.divCnt) == 2'h3)
    else $error("result latched outside instruction cycle");
  pin_drive_a: assert property (pinDrvOe[2] && $past(state_r.cmpOe[0]) |-> $past(state_r.cmpEn[0])
                                && !$past(state_r.pinDir[2]))
    else $error("comparator pin driven while not allowed");
  sync_path_a: assert property (state_r.sync2 == $past(cmpDecisionAsync, 2) or $past(sys_rst, 2))
    else $error("synchronizer depth wrong");
  write_once_a: assert property (writeNow && slot == 4'h1 |=> state_r.dacCode == $past(pwdata[4:0]))
    else $error("level code write lost");

  // ----------------------------------------------------------------
  // dac checks
  // ----------------------------------------------------------------
  // ladder controls mirror the registers one clock later
  ladder_off_a: assert property (!state_r.dac_enable |=> !dacLadderOn)
    else $error("ladder on while disabled");
  write_ctrl_a: assert property (writeNow && slot == 4'h0 |=>
                                 state_r.dac_enable == $past(pwdata[rdc_pkg::DAC_EN_BIT]))
    else $error("enable write lost");
  tap_follow_a: assert property (dacTap == $past(state_r.dacCode))
    else $error("ladder tap does not follow code");
  src_follow_a: assert property (dacSrcExt == $past(state_r.dac_pos_source_sel))
    else $error("source select does not follow register");
  tie_low_a: assert property (dacTieLow |-> !dacLadderOn && dacTap == 5'h00)
    else $error("tie low outside idle zero code");
  ref_conn_a: assert property (refConnect == $past({state_r.dac_pin2_out_en, state_r.dac_pin1_out_en}))
    else $error("reference pin connection wrong");
  pin_b_off_a: assert property (refConnect[1] |-> !pinDrvOe[1] && !pinInEn[1])
    else $error("second reference pin still digital");
  read_b_zero_a: assert property (pready && !pwrite && slot == 4'h7 && state_r.dac_pin2_out_en
                                  |-> prdata[1] == 1'b0)
    else $error("second reference pin read nonzero");

  // ----------------------------------------------------------------
  // comparator checks
  // ----------------------------------------------------------------
  // power and speed controls follow the register bits
  power_follow_a: assert property (cmpPowerOn == $past(state_r.cmpEn))
    else $error("comparator power does not follow enable");
  speed_follow_a: assert property (cmpFastMode == $past(state_r.cmpSp))
    else $error("speed mode does not follow select");
  cmp1_off_a: assert property (!state_r.cmpEn[1] ##1 !state_r.cmpEn[1] [*4]
                               |-> state_r.cmpResult[1] == 1'b0)
    else $error("disabled second comparator shows result");
  summary_read_a: assert property (pready && !pwrite && slot == 4'h4
                                   |-> prdata[1:0] == $past(state_r.cmpResult))
    else $error("summary read differs from results");
  result0_read_a: assert property (pready && !pwrite && slot == 4'h2
                                   |-> prdata[rdc_pkg::CMP_RES_BIT] == $past(state_r.cmpResult[0]))
    else $error("first result bit read wrong");
  result1_read_a: assert property (pready && !pwrite && slot == 4'h3
                                   |-> prdata[rdc_pkg::CMP_RES_BIT] == $past(state_r.cmpResult[1]))
    else $error("second result bit read wrong");

  // ----------------------------------------------------------------
  // pin checks
  // ----------------------------------------------------------------
  // override carries the unlatched decision, else the port latch
  pin_data_a: assert property ($past(state_r.cmpOe[0]) && !$past(state_r.cmpInv[0])
                               |-> pinDrvOut[2] == $past(state_r.sync2[0]))
    else $error("comparator pin data wrong");
  latch_data_a: assert property (!$past(state_r.cmpOe[0])
                                 |-> pinDrvOut[2] == $past(state_r.pinLatch[2]))
    else $error("port latch not on pin");

  cov_dac_on_c:   cover property (dacLadderOn && refConnect == 2'h3);
  cov_cmp_pin_c:  cover property (pinDrvOe[2] && state_r.cmpOe[0] && state_r.cmpInv[0]);
  cov_slverr_c:   cover property (pready && pslverr);
  cov_low_power_c: cover property (cmpPowerOn[1] && !cmpFastMode[1]);
  cov_tie_high_c: cover property (dacTieHigh);

endmodule

`default_nettype wire

// file: rdc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// ladder, comparator and pad model
// ------------------------------------------------
module rdc_analog_model #(
  parameter int VDD_MV  = 3300,
  parameter int VREF_MV = 2048
) (
  input  wire logic        dacLadderOn,
  input  wire logic [4:0]  dacTap,
  input  wire logic        dacTieHigh,
  input  wire logic        dacSrcExt,
  input  wire logic [1:0]  cmpPowerOn,
  input  wire logic [3:0]  pinDrvOe,
  input  wire logic [3:0]  pinDrvOut,
  input  wire logic [3:0]  extPin,
  input  wire logic [15:0] vMinus0,
  input  wire logic [15:0] vMinus1,
  output var  logic [15:0] dacMv,
  output var  logic [1:0]  cmpDecisionAsync,
  output var  logic [3:0]  pinIn
);
  int vTop;
  int vOut;

  // ladder level, then comparators with the ladder on the plus input
  always_comb
  begin
    vTop = dacSrcExt ? VREF_MV : VDD_MV;
    if (dacLadderOn)
      vOut = vTop * int'(dacTap) / 32;
    else if (dacTieHigh)
      vOut = vTop;
    else
      vOut = 0;
    dacMv = 16'(vOut);
    // a powered-down comparator gives junk, here a one
    cmpDecisionAsync[0] = cmpPowerOn[0] ? (vOut > int'(vMinus0)) : 1'b1;
    cmpDecisionAsync[1] = cmpPowerOn[1] ? (vOut > int'(vMinus1)) : 1'b1;
  end

  // driven pads show their own value, released pads the outside level
  assign pinIn = (pinDrvOe & pinDrvOut) | (~pinDrvOe & extPin);
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  cmpDecisionAsync;
  logic [3:0]  pinIn;
  logic [3:0]  pinDrvOe;
  logic [3:0]  pinDrvOut;
  logic [3:0]  pinInEn;
  logic        dacLadderOn;
  logic [4:0]  dacTap;
  logic        dacTieHigh;
  logic        dacTieLow;
  logic        dacSrcExt;
  logic [1:0]  refConnect;
  logic [1:0]  cmpPowerOn;
  logic [1:0]  cmpFastMode;
  logic [3:0]  extPin;
  logic [15:0] vMinus0;
  logic [15:0] vMinus1;
  logic [15:0] dacMv;
  logic [31:0] rdat;
  logic        rerr;
  int          errors;
  int          cmp_count;

  ref_dac_and_comparator_ctrl u_ref_dac_and_comparator_ctrl (
    .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cmpDecisionAsync, .pinIn, .pinDrvOe, .pinDrvOut,
    .pinInEn, .dacLadderOn, .dacTap, .dacTieHigh, .dacTieLow, .dacSrcExt,
    .refConnect, .cmpPowerOn, .cmpFastMode);

  rdc_analog_model u_rdc_analog_model (
    .dacLadderOn, .dacTap, .dacTieHigh, .dacSrcExt, .cmpPowerOn, .pinDrvOe,
    .pinDrvOut, .extPin, .vMinus0, .vMinus1, .dacMv, .cmpDecisionAsync, .pinIn);

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {24'h000000, a};
    pwdata  <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    // wait for the edge at which pready is sampled high; take data there
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk("pready wait", 32'h00000000, (n == 50) ? 32'h00000001 : 32'h00000000);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h000000, e}, rdat);
  endtask

  // comparator path settles within two instruction cycles
  task settle;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask

  task end_of_test;
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task t_reset;
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h04);
    chk("cmpFastMode", 2'h3, cmpFastMode);
    chk("dacTieLow", 1'b1, dacTieLow);
    chk("refConnect", 2'h0, refConnect);
    chk("cmpPowerOn", 2'h0, cmpPowerOn);
  endtask

  task t_dac;
    wr(8'h14, 8'h00);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'hB4);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h1F);
    settle;
    chk("refConnect", 2'h3, refConnect);
    chk("pinDrvOe", 2'h0, pinDrvOe[1:0]);
    chk("pinInEn", 2'h0, pinInEn[1:0]);
    chk("dacSrcExt", 1'b1, dacSrcExt);
    chk("dacLadderOn", 1'b1, dacLadderOn);
    chk("dacTap", 5'h1F, dacTap);
    chk("dacMv", 16'h07C0, dacMv);
    wr(8'h14, 8'h0F);
    rd(8'h1C, 8'h0C);
    wr(8'h00, 8'h04);
    settle;
    chk("dacLadderOn", 1'b0, dacLadderOn);
    rd(8'h1C, 8'h0F);
    wr(8'h00, 8'hFF);
  endtask

  task t_tie;
    wr(8'h04, 8'h1F);
    wr(8'h20, 8'h01);
    settle;
    chk("dacTieHigh", 1'b1, dacTieHigh);
    chk("dacMv", 16'h0CE4, dacMv);
    wr(8'h20, 8'h00);
    settle;
    chk("dacTieHigh", 1'b0, dacTieHigh);
    wr(8'h04, 8'h00);
    settle;
    chk("dacTieLow", 1'b1, dacTieLow);
  endtask

  task t_cmp;
    wr(8'h04, 8'h10);
    wr(8'h00, 8'h80);
    wr(8'h08, 8'h84);
    wr(8'h0C, 8'h84);
    settle;
    rd(8'h08, 8'hC4);
    rd(8'h0C, 8'h84);
    rd(8'h10, 8'h01);
    chk("cmpPowerOn", 2'h3, cmpPowerOn);
    wr(8'h08, 8'h94);
    wr(8'h0C, 8'h90);
    settle;
    rd(8'h10, 8'h02);
    chk("cmpFastMode", 2'h1, cmpFastMode);
    wr(8'h0C, 8'h00);
    wr(8'h10, 8'hFF);
    settle;
    rd(8'h0C, 8'h00);
    rd(8'h10, 8'h00);
  endtask

  task t_pin;
    wr(8'h14, 8'h00);
    wr(8'h08, 8'hA4);
    settle;
    chk("pinDrvOe", 1'b1, pinDrvOe[2]);
    chk("pinDrvOut", 1'b1, pinDrvOut[2]);
    wr(8'h08, 8'h24);
    settle;
    chk("pinDrvOe", 1'b0, pinDrvOe[2]);
    chk("pinDrvOut", 1'b1, pinDrvOut[2]);
    wr(8'h14, 8'h04);
    wr(8'h08, 8'hA4);
    settle;
    chk("pinDrvOe", 1'b0, pinDrvOe[2]);
    apb(1'b0, 8'h40, 8'h00);
    chk("pslverr", 1'b1, rerr);
    chk("prdata", 32'h00000000, rdat);
  endtask

  // main sequence
  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    extPin = 4'hF;
    vMinus0 = 16'h03E8;
    vMinus1 = 16'h07D0;
    errors = 0;
    cmp_count = 0;
    t_reset;
    t_dac;
    t_reset;
    t_tie;
    t_cmp;
    t_pin;
    end_of_test;
  end

  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
